//--- hdl/sgc_global_ctrl.sv
// global control registers 5..7 with queue arbiter, sniff match, null-vid and storm limiter
`timescale 1ns/1ps
module sgc_global_ctrl
  import sgc_pkg::*;
#(
  parameter int NPORT = 3,
  parameter int INT100_CYC = SGC_INT100_CYC,
  parameter int INT10_CYC = SGC_INT10_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // strap pins, sampled on the edge just after reset release
  input wire logic mii_duplex_strap_pin,
  input wire logic mii_flow_strap_pin,
  input wire logic mii_speed_strap_pin,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regAck,
  // decoded configuration
  output sgc_fwd_s fwdCfg,
  output sgc_mode_s modeCfg,
  // egress queue arbiter
  input wire logic [3:0] queueBusy,
  input wire logic txSlotReq,
  output logic [1:0] txQueue,
  output logic txQueueValid,
  // sniff match
  input wire logic sniffSrcHit,
  input wire logic sniffDstHit,
  output logic sniffMirror,
  // null vid replacement
  input wire logic [11:0] frameVid,
  input wire logic [11:0] portVid,
  output logic [11:0] outVid,
  // storm limiter, one block pulse per 64 bytes per port
  input wire logic [NPORT-1:0] stormBlock,
  output logic [NPORT-1:0] stormDrop
);
  // ----------------------------------------------------------------
  // reset release and strap capture
  // ----------------------------------------------------------------
  logic rstMeta, rstSync;
  logic [2:0] strapMeta, strapSync;
  logic strapsLoaded;
  logic [7:0] storm;

  // reset released through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // straps sampled every edge, synchronised first; the value loaded is the one sampled just after resetn releases
  always_ff @(posedge clock) begin
    strapMeta <= {mii_duplex_strap_pin, mii_flow_strap_pin, mii_speed_strap_pin};
    strapSync <= strapMeta;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // forwarding options; reserved bits kept as written, software leaves them 00
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      fwdCfg <= SGC_RST_FWD;
    end else if (regWrite && regAddr == SGC_OFS_FWD) begin
      fwdCfg <= regWdata;
    end
  end

  // mode register; straps loaded on the first edge after release
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      modeCfg <= '0;
      strapsLoaded <= 1'b0;
    end else begin
      strapsLoaded <= 1'b1;
      if (!strapsLoaded) begin
        modeCfg.miiHalfDuplex <= strapSync[2];
        modeCfg.miiFlowCtrl <= strapSync[1];
        modeCfg.miiTenMbps <= strapSync[0];
      end else if (regWrite && regAddr == SGC_OFS_MODE) begin
        modeCfg <= regWdata;
      end
    end
  end

  // low storm byte
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      storm <= SGC_RST_STORM_LO;
    end else if (regWrite && regAddr == SGC_OFS_STORM_LO) begin
      storm <= regWdata;
    end
  end

  // read path, unmapped offsets read zero
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      regRdata <= 8'h00;
      regAck <= 1'b0;
    end else begin
      regAck <= regRead | regWrite;
      case (regAddr)
        SGC_OFS_FWD: regRdata <= fwdCfg;
        SGC_OFS_MODE: regRdata <= modeCfg;
        SGC_OFS_STORM_LO: regRdata <= storm;
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // egress queue arbiter
  // ----------------------------------------------------------------
  // highest busy queue
  function automatic logic [1:0] topQueue(input logic [3:0] busy);
    topQueue = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (busy[i]) topQueue = 2'(i);
    end
  endfunction

  logic [3:0] credit [4];
  logic [3:0] next_credit [4];
  logic [1:0] pick;
  logic anyCredit;

  // weights 8:4:2:1, each empty queue donates one unit to the top queue
  always_comb begin
    logic [3:0] extra;
    extra = 4'd0;
    for (int i = 0; i < 4; i++) begin
      if (!queueBusy[i]) extra = extra + 4'd1;
    end
    for (int i = 0; i < 4; i++) begin
      next_credit[i] = queueBusy[i] ? 4'(4'd1 << i) : 4'd0;
      if (queueBusy[i] && 2'(i) == topQueue(queueBusy)) begin
        next_credit[i] = 4'(next_credit[i] + extra);
      end
    end
  end

  // pick the highest queue with credit left; strict mode ignores credit
  always_comb begin
    pick = topQueue(queueBusy);
    anyCredit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (queueBusy[i] && credit[i] != 4'd0) begin
        pick = 2'(i);
        anyCredit = 1'b1;
      end
    end
    if (!fwdCfg.wfqOn) pick = topQueue(queueBusy);
  end

  // credits refilled when the round is spent
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      for (int i = 0; i < 4; i++) credit[i] <= 4'd0;
      txQueue <= 2'd0;
      txQueueValid <= 1'b0;
    end else begin
      txQueueValid <= txSlotReq && (queueBusy != 4'd0);
      if (txSlotReq && queueBusy != 4'd0) begin
        if (fwdCfg.wfqOn && !anyCredit) begin
          // round spent: reload and serve the top queue from the fresh round
          for (int i = 0; i < 4; i++) credit[i] <= next_credit[i];
          credit[topQueue(queueBusy)] <= 4'(next_credit[topQueue(queueBusy)] - 4'd1);
          txQueue <= topQueue(queueBusy);
        end else begin
          if (fwdCfg.wfqOn) credit[pick] <= credit[pick] - 4'd1;
          txQueue <= pick;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sniff match and null vid
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      sniffMirror <= 1'b0;
      outVid <= 12'h000;
    end else begin
      sniffMirror <= fwdCfg.sniffAnd ? (sniffSrcHit & sniffDstHit)
                                     : (sniffSrcHit | sniffDstHit);
      outVid <= (modeCfg.nullVidReplace && frameVid == 12'h000) ? portVid : frameVid;
    end
  end

  // ----------------------------------------------------------------
  // broadcast storm limiter
  // ----------------------------------------------------------------
  logic [10:0] stormLimit;
  logic [31:0] tick;
  logic intervalEnd;
  assign stormLimit = {modeCfg.stormHigh, storm};
  assign intervalEnd = (tick == 32'd0);

  // interval length follows the MII speed bit
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      tick <= 32'(INT100_CYC - 1);
    end else if (intervalEnd) begin
      tick <= modeCfg.miiTenMbps ? 32'(INT10_CYC - 1) : 32'(INT100_CYC - 1);
    end else begin
      tick <= tick - 32'd1;
    end
  end

  // per-port block counters; drop once the allowance is used up
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : gPort
      logic [11:0] blocks;
      always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
          blocks <= 12'h000;
          stormDrop[p] <= 1'b0;
        end else if (intervalEnd) begin
          blocks <= 12'h000;
          stormDrop[p] <= 1'b0;
        end else begin
          if (stormBlock[p] && blocks != 12'hfff) blocks <= blocks + 12'h001;
          stormDrop[p] <= (blocks >= {1'b0, stormLimit});
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sniff_and: assert property (@(posedge clock) disable iff (!rstSync)
    fwdCfg.sniffAnd && !(sniffSrcHit && sniffDstHit) |=> !sniffMirror)
    else $error("and-mode sniff mirrored without both hits");
  a_sniff_or: assert property (@(posedge clock) disable iff (!rstSync)
    !fwdCfg.sniffAnd && (sniffSrcHit || sniffDstHit) |=> sniffMirror)
    else $error("or-mode sniff missed a hit");
  a_strict_top: assert property (@(posedge clock) disable iff (!rstSync)
    !fwdCfg.wfqOn && txSlotReq && queueBusy[3] |=> txQueue == 2'd3)
    else $error("strict priority skipped top queue");
  a_null_vid: assert property (@(posedge clock) disable iff (!rstSync)
    modeCfg.nullVidReplace && frameVid == 12'h000 |=> outVid == $past(portVid))
    else $error("null vid not replaced");
  a_no_replace: assert property (@(posedge clock) disable iff (!rstSync)
    !modeCfg.nullVidReplace |=> outVid == $past(frameVid))
    else $error("vid altered while replacement off");
  a_strap_load: assert property (@(posedge clock) disable iff (!rstSync)
    !strapsLoaded |=> modeCfg.miiHalfDuplex == $past(strapSync[2]))
    else $error("duplex strap not loaded");
  a_storm_reset: assert property (@(posedge clock) disable iff (!rstSync)
    $rose(strapsLoaded) |-> storm == SGC_RST_STORM_LO && modeCfg.stormHigh == 3'h0)
    else $error("storm rate reset value wrong");
  a_fwd_write: assert property (@(posedge clock) disable iff (!rstSync)
    regWrite && regAddr == SGC_OFS_FWD ##1 regRead && regAddr == SGC_OFS_FWD && !regWrite
    |=> regRdata == $past(regWdata, 2))
    else $error("forwarding register readback mismatch");
  a_wfq_share: assert property (@(posedge clock) disable iff (!rstSync)
    fwdCfg.wfqOn && txSlotReq && queueBusy == 4'hf && credit[3] != 4'd0 |=> txQueue == 2'd3)
    else $error("q3 credit not served first");

  c_wfq: cover property (@(posedge clock) disable iff (!rstSync)
    fwdCfg.wfqOn && txQueueValid && txQueue == 2'd0);
  c_drop: cover property (@(posedge clock) disable iff (!rstSync) stormDrop[0]);
  c_mirror: cover property (@(posedge clock) disable iff (!rstSync)
    fwdCfg.sniffAnd && sniffMirror);
endmodule

//--- hdl/sgc_pkg.sv
// package: offsets, field positions, reset values and timing for global control 3/4
package sgc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SGC_OFS_FWD = 8'h05;
  localparam logic [7:0] SGC_OFS_MODE = 8'h06;
  localparam logic [7:0] SGC_OFS_STORM_LO = 8'h07;
  localparam logic [7:0] SGC_RST_FWD = 8'h00;
  localparam logic [7:0] SGC_RST_STORM_LO = 8'h63;
  localparam logic [2:0] SGC_RST_STORM_HI = 3'h0;
  localparam logic [2:0] SGC_RSVD_HI = 3'd2;
  localparam logic [2:0] SGC_RSVD_LO = 3'd1;
  // ----------------------------------------------------------------
  // timing at 200 MHz
  // ----------------------------------------------------------------
  localparam int SGC_CLK_MHZ = 200;
  localparam int SGC_INT100_MS = 67;
  localparam int SGC_INT10_MS = 500;
  localparam int SGC_INT100_CYC = SGC_INT100_MS * 1000 * SGC_CLK_MHZ;
  localparam int SGC_INT10_CYC = SGC_INT10_MS * 1000 * SGC_CLK_MHZ;
  localparam int SGC_BLOCK_BYTES = 64;

  // decoded forwarding options
  typedef struct packed {
    logic vlanOn;
    logic igmpSnoop;
    logic mldSnoop;
    logic mldOption;
    logic wfqOn;
    logic [1:0] rsvd;
    logic sniffAnd;
  } sgc_fwd_s;

  // decoded port mode and storm high bits
  typedef struct packed {
    logic repeaterOn;
    logic miiHalfDuplex;
    logic miiFlowCtrl;
    logic miiTenMbps;
    logic nullVidReplace;
    logic [2:0] stormHigh;
  } sgc_mode_s;
endpackage

//--- bench/switch_global_control_3_4_tb.sv
// self-checking bench for the global control register block
`timescale 1ns/1ps
module switch_global_control_3_4_tb
  import sgc_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock = 0, resetn = 0, regWrite = 0, regRead = 0, txSlotReq = 0;
  logic sniffSrcHit = 0, sniffDstHit = 0, regAck, txQueueValid, sniffMirror;
  // straps pick half duplex, no flow control, 10 Mbit
  logic mii_duplex_strap_pin = 1, mii_flow_strap_pin = 0, mii_speed_strap_pin = 1;
  logic [7:0] regAddr = 0, regWdata = 0, regRdata, lfsr = 8'h09, v;
  logic [3:0] queueBusy = 0;
  logic [1:0] txQueue;
  logic [11:0] frameVid = 0, portVid = 0, outVid;
  logic [2:0] stormBlock = 0, stormDrop;
  sgc_fwd_s fwdCfg;
  sgc_mode_s modeCfg;
  int n_errors = 0, n_tests = 0, cyc = 0;
  logic [8:0] rdQ[$];
  logic [1:0] txQ[$];

  // short intervals keep the storm test to a few hundred cycles
  sgc_global_ctrl #(.NPORT(3), .INT100_CYC(200), .INT10_CYC(400)) u_sgc_global_ctrl (
    .clock, .resetn, .mii_duplex_strap_pin, .mii_flow_strap_pin, .mii_speed_strap_pin,
    .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regAck, .fwdCfg, .modeCfg,
    .queueBusy, .txSlotReq, .txQueue, .txQueueValid, .sniffSrcHit, .sniffDstHit,
    .sniffMirror, .frameVid, .portVid, .outVid, .stormBlock, .stormDrop);

  initial begin
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one register access; the expected read value is queued for the monitor
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input logic [7:0] exp);
    @(posedge clock);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
    rdQ.push_back({!w, exp});
    @(posedge clock);
    regWrite <= 0;
    regRead <= 0;
  endtask

  // one transmit slot with the expected queue noted
  task automatic slot(input logic [3:0] b, input logic [1:0] q);
    @(posedge clock);
    txSlotReq <= 1;
    queueBusy <= b;
    txQ.push_back(q);
    @(posedge clock);
    txSlotReq <= 0;
  endtask

  // monitor: pops the oldest note whenever an answer appears; also the hang limit
  always @(posedge clock) begin
    logic [8:0] e;
    cyc++;
    if (regAck === 1'b1 && rdQ.size() > 0) begin
      e = rdQ.pop_front();
      if (e[8]) check(regRdata, e[7:0], "read data");
    end
    if (txQueueValid === 1'b1) check(txQueue, txQ.pop_front(), "queue");
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1;
    repeat (4) @(posedge clock);
    access(0, SGC_OFS_FWD, 0, 8'h00);
    access(0, SGC_OFS_MODE, 0, 8'h50);
    access(0, SGC_OFS_STORM_LO, 0, 8'h63);
    access(1, 8'h08, 8'hff, 0);
    access(0, 8'h08, 0, 8'h00);
    $display("test reset values done");
    // random writes and readbacks, one idle cycle between accesses; software keeps the reserved pair at 00
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsrNext(lfsr);
      v = lfsr & 8'hf9;
      access(1, SGC_OFS_FWD, v, 0);
      access(1, SGC_OFS_MODE, lfsr, 0);
      access(0, SGC_OFS_FWD, 0, v);
      access(0, SGC_OFS_MODE, 0, lfsr);
      check(fwdCfg, v, "fwd outputs");
      check(modeCfg, lfsr, "mode outputs");
    end
    $display("test register access done");
    access(1, SGC_OFS_FWD, 8'h08, 0);
    // one full 8:4:2:1 round of 15 slots, then the next round opens on q3
    for (int i = 0; i < 16; i++) begin
      slot(4'hf, (i < 8 || i == 15) ? 2'd3 : i < 12 ? 2'd2 : i < 14 ? 2'd1 : 2'd0);
    end
    // q2 empties mid-round: the open round finishes, then q3 gets 8+1
    for (int i = 0; i < 22; i++) begin
      slot(4'hb, i < 7 ? 2'd3 : i < 9 ? 2'd1 : i < 10 ? 2'd0 :
                 i < 19 ? 2'd3 : i < 21 ? 2'd1 : 2'd0);
    end
    access(1, SGC_OFS_FWD, 8'h00, 0);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsrNext(lfsr);
      v = {lfsr[7:1], 1'b1};
      slot(v[3:0], v[3] ? 2'd3 : v[2] ? 2'd2 : v[1] ? 2'd1 : 2'd0);
    end
    $display("test queue arbiter done");
    for (int m = 0; m < 2; m++) begin
      access(1, SGC_OFS_FWD, m[7:0], 0);
      for (int k = 0; k < 4; k++) begin
        @(posedge clock);
        sniffSrcHit <= k[0];
        sniffDstHit <= k[1];
        @(posedge clock);
        #1 check(sniffMirror, m ? (k == 3) : (k != 0), "sniff");
      end
    end
    $display("test sniff done");
    // second pass leaves storm high bits 000 and 100 Mbit interval
    for (int m = 0; m < 2; m++) begin
      access(1, SGC_OFS_MODE, m ? 8'h00 : 8'h08, 0);
      for (int k = 0; k < 2; k++) begin
        lfsr = lfsrNext(lfsr);
        @(posedge clock);
        frameVid <= k ? {4'h0, lfsr} : 12'h000;
        portVid <= {lfsr, 4'h5};
        @(posedge clock);
        #1 check(outVid, k ? {4'h0, lfsr} : (m ? 12'h000 : {lfsr, 4'h5}), "vid");
      end
    end
    $display("test null vid done");
    access(1, SGC_OFS_STORM_LO, 8'h02, 0);
    // align to a fresh interval so no boundary falls inside the burst
    @(posedge clock iff u_sgc_global_ctrl.intervalEnd);
    stormBlock <= 3'b001;
    repeat (2) @(posedge clock);
    stormBlock <= 3'b000;
    @(posedge clock);
    #1 check(stormDrop, 3'b001, "storm limit hit");
    repeat (210) @(posedge clock);
    #1 check(stormDrop, 3'b000, "storm interval end");
    $display("test storm done");
    close_out();
  end
endmodule
